// File: include/dmlo_pkg.sv
/*
 Shared constants, opcode encodings, register offsets and the decode
 function of the multiply, load and logic instruction group.
 Assumes a 16-bit instruction word and a 256-word on-chip data memory.
*/
package dmlo_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ACC_W = 32;
	localparam int MEM_AW = 8;
	localparam int DIR_OFF_W = 7;
	localparam int IMM_W = 13;
	localparam int REG_AW = 4;

	// ----------------------------------------------------------------
	// Opcodes and instruction fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_LOAD_MCAND = 8'h6A;
	localparam logic [7:0] OP_LOAD_MCAND_ACC = 8'h6C;
	localparam logic [7:0] OP_LOAD_ACC_MOVE = 8'h6B;
	localparam logic [7:0] OP_MODIFY_AUX = 8'h68;
	localparam logic [7:0] OP_OR_LOW = 8'h7A;
	localparam logic [7:0] OP_MULT_MEM = 8'h6D;
	localparam logic [2:0] OP_MULT_IMM_TOP = 3'h4;
	localparam logic [15:0] OP_NO_OP = 16'h7F80;
	localparam int MODE_BIT = 7;
	localparam int IND_INC_BIT = 5;
	localparam int IND_DEC_BIT = 4;
	localparam int IND_KEEP_PTR_BIT = 3;
	localparam int IND_NEXT_PTR_BIT = 0;

	// ----------------------------------------------------------------
	// Arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [ACC_W-1:0] ACC_MAX_POS = 32'h7FFFFFFF;
	localparam logic [ACC_W-1:0] ACC_MAX_NEG = 32'h80000000;
	localparam logic [ACC_W-1:0] PROD_MIN_SQUARE = 32'hC0000000;
	localparam logic [DATA_W-1:0] DATA_MIN_NEG = 16'h8000;
	localparam logic [MEM_AW-1:0] ADDR_STEP = 8'h01;
	localparam logic [DATA_W-1:0] AUX_STEP = 16'h0001;

	// ----------------------------------------------------------------
	// Register port map and reset values
	// ----------------------------------------------------------------
	localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
	localparam logic [REG_AW-1:0] REG_ACC_LO = 4'h2;
	localparam logic [REG_AW-1:0] REG_ACC_HI = 4'h3;
	localparam logic [REG_AW-1:0] REG_PROD_LO = 4'h4;
	localparam logic [REG_AW-1:0] REG_PROD_HI = 4'h5;
	localparam logic [REG_AW-1:0] REG_MCAND = 4'h6;
	localparam logic [REG_AW-1:0] REG_AUX0 = 4'h7;
	localparam logic [REG_AW-1:0] REG_AUX1 = 4'h8;
	localparam int CTRL_SAT_BIT = 0;
	localparam int CTRL_PAGE_BIT = 1;
	localparam int ST_OVF_BIT = 0;
	localparam int ST_PTR_BIT = 1;
	localparam int ST_BLOCK_BIT = 2;
	localparam logic [ACC_W-1:0] ACC_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic BIT_RESET = 1'h0;

	typedef enum logic [3:0] {
		OPK_NONE, OPK_LOAD_MCAND, OPK_LOAD_ACC, OPK_LOAD_ACC_MOVE, OPK_MODIFY_AUX,
		OPK_MULT_MEM, OPK_MULT_IMM, OPK_NO_OP, OPK_OR_LOW
	} dmlo_op_type;

	function automatic dmlo_op_type dmlo_decode(input logic [DATA_W-1:0] w);
		dmlo_op_type k;
		k = OPK_NONE;
		if (w == OP_NO_OP) begin
			k = OPK_NO_OP;
		end else if (w[15:13] == OP_MULT_IMM_TOP) begin
			k = OPK_MULT_IMM;
		end else begin
			case (w[15:8])
				OP_LOAD_MCAND: k = OPK_LOAD_MCAND;
				OP_LOAD_MCAND_ACC: k = OPK_LOAD_ACC;
				OP_LOAD_ACC_MOVE: k = OPK_LOAD_ACC_MOVE;
				OP_MODIFY_AUX: k = OPK_MODIFY_AUX;
				OP_MULT_MEM: k = OPK_MULT_MEM;
				OP_OR_LOW: k = OPK_OR_LOW;
				default: k = OPK_NONE;
			endcase
		end
		return k;
	endfunction
endpackage

// File: include/dmlo_arith_if.sv
/*
 Carrier between the execute core, the multiplier and the accumulate adder.
 Assumes all three sit on the same clock; the paths are purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface dmlo_arith_if;
	logic [15:0] mul_a;
	logic [15:0] mul_b;
	logic [31:0] mul_p;
	logic [31:0] add_acc;
	logic [31:0] add_prod;
	logic add_sat;
	logic [31:0] add_sum;
	logic add_ovf;
	modport core (output mul_a, mul_b, add_acc, add_prod, add_sat, input mul_p, add_sum, add_ovf);
	modport mul_side (input mul_a, mul_b, output mul_p);
	modport add_side (input add_acc, add_prod, add_sat, output add_sum, add_ovf);
endinterface
`default_nettype wire

// File: verilog/dmlo_mult.sv
/*
 Signed 16 by 16 multiplier feeding the product register.
 Assumes operands are stable for the whole cycle; result is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module dmlo_mult
	import dmlo_pkg::*;
(
	// Operands and product
	dmlo_arith_if.mul_side arith
);
	logic signed [ACC_W-1:0] full_prod;

	// Only 31 product bits exist; bit 30 is copied up, so the
	// most negative square wraps to a negative value on purpose.
	always_comb begin
		full_prod = $signed(arith.mul_a) * $signed(arith.mul_b);
		arith.mul_p = {full_prod[ACC_W-2], full_prod[ACC_W-2:0]};
	end
endmodule
`default_nettype wire

// File: verilog/dmlo_acc_add.sv
/*
 Accumulator plus product adder with overflow detect and saturation.
 Assumes both operands are two's complement 32-bit values.
*/
`timescale 1ns/1ps
`default_nettype none
module dmlo_acc_add
	import dmlo_pkg::*;
(
	// Operands, mode and result
	dmlo_arith_if.add_side arith
);
	logic [ACC_W:0] wide_sum;

	always_comb begin
		wide_sum = {arith.add_acc[ACC_W-1], arith.add_acc} +
			{arith.add_prod[ACC_W-1], arith.add_prod};
		arith.add_ovf = wide_sum[ACC_W] ^ wide_sum[ACC_W-1];
		if (arith.add_ovf && arith.add_sat) begin
			arith.add_sum = wide_sum[ACC_W] ? ACC_MAX_NEG : ACC_MAX_POS;
		end else begin
			arith.add_sum = wide_sum[ACC_W-1:0];
		end
	end
endmodule
`default_nettype wire

// File: verilog/dmlo_core.sv
/*
 Execute stage for the multiplicand load, accumulate, auxiliary modify,
 multiply, no-operation and OR-low instructions, with a small register port.
 Assumes an asynchronous-read data memory answering in the same cycle and a
 sequencer that presents one instruction per cycle on the same clock.
*/
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Load-multiplicand copies the addressed memory word into the multiplicand, one cycle.
// - Opcode 6Ah is load-multiplicand; bit 7 picks direct offset or indirect.
// - Load-and-accumulate also adds product to accumulator, overflow flag and saturation apply.
// - Opcode 6Ch is load-and-accumulate; bit 7 picks direct or indirect.
// - Load-accumulate-move also writes the memory word to the next address.
// - Opcode 6Bh is load-accumulate-move; bit 7 picks direct or indirect.
// - Indirect modify-aux steps current aux register, may reload pointer, no memory access.
// - Opcode 68h is modify-aux; in direct mode it changes nothing.
// - Indirect modify-aux without step behaves as load-aux-pointer.
// - Multiply puts signed multiplicand times memory word into product register.
// - Interrupts are held off between any multiply and the next instruction.
// - Most negative value squared yields C0000000h in the product register.
// - Multiply-immediate uses a sign-extended 13-bit constant from the instruction.
// - No-operation only advances the program counter.
// - OR puts memory word into accumulator low half, high half kept.
// - Opcode 7Ah is OR; bit 7 picks direct or indirect.
// - The aux pointer picks which aux register addresses indirectly.
// - Overflow without saturation sets the flag and keeps the wrapped sum.
module dmlo_core
	import dmlo_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Instruction from the sequencer
	input wire logic instr_valid,
	input wire logic [DATA_W-1:0] instr_word,
	output logic pc_inc,
	output logic int_block,
	// Data memory
	output logic mem_rd_en,
	output logic [MEM_AW-1:0] mem_rd_addr,
	input wire logic [DATA_W-1:0] mem_rd_data,
	output logic mem_wr_en,
	output logic [MEM_AW-1:0] mem_wr_addr,
	output logic [DATA_W-1:0] mem_wr_data,
	// Register port
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rd_data
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [ACC_W-1:0] acc_r, acc_nxt;
	logic [ACC_W-1:0] prod_r, prod_nxt;
	logic [DATA_W-1:0] mcand_r, mcand_nxt;
	logic [DATA_W-1:0] aux_address_reg_r [2];
	logic [DATA_W-1:0] aux_address_reg_nxt [2];
	logic aux_select_pointer_r, aux_select_pointer_nxt;
	logic overflow_flag_r, overflow_flag_nxt;
	logic int_block_r, int_block_nxt;
	logic overflow_saturate_mode_r, overflow_saturate_mode_nxt;
	logic page_select_bit_r, page_select_bit_nxt;
	logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
	dmlo_op_type op;
	logic indirect, mem_op, addr_op, step_up, step_down, ovf_clr;
	logic [DATA_W-1:0] cur_aux;
	logic [DATA_W-1:0] imm_ext;

	dmlo_arith_if arith ();

	dmlo_mult u_mult (
		.arith(arith.mul_side)
	);

	dmlo_acc_add u_add (
		.arith(arith.add_side)
	);

	// ----------------------------------------------------------------
	// Decode and execute
	// ----------------------------------------------------------------
	always_comb begin
		op = instr_valid ? dmlo_decode(instr_word) : OPK_NONE;
		indirect = instr_word[MODE_BIT];
		cur_aux = aux_address_reg_r[aux_select_pointer_r];
		imm_ext = {{(DATA_W-IMM_W){instr_word[IMM_W-1]}}, instr_word[IMM_W-1:0]};
		mem_op = (op == OPK_LOAD_MCAND) || (op == OPK_LOAD_ACC) ||
			(op == OPK_LOAD_ACC_MOVE) || (op == OPK_MULT_MEM) || (op == OPK_OR_LOW);
		addr_op = mem_op || (op == OPK_MODIFY_AUX);
		step_up = instr_word[IND_INC_BIT] && !instr_word[IND_DEC_BIT];
		step_down = instr_word[IND_DEC_BIT] && !instr_word[IND_INC_BIT];
		// Indirect address comes from the selected aux register
		mem_rd_addr = indirect ? cur_aux[MEM_AW-1:0] :
			{page_select_bit_r, instr_word[DIR_OFF_W-1:0]};
		mem_rd_en = mem_op;
		mem_wr_en = (op == OPK_LOAD_ACC_MOVE);
		mem_wr_addr = mem_rd_addr + ADDR_STEP;
		mem_wr_data = mem_rd_data;
		pc_inc = (op != OPK_NONE);
		arith.mul_a = mcand_r;
		arith.mul_b = (op == OPK_MULT_IMM) ? imm_ext : mem_rd_data;
		arith.add_acc = acc_r;
		arith.add_prod = prod_r;
		arith.add_sat = overflow_saturate_mode_r;
		ovf_clr = reg_wr && (reg_addr == REG_STATUS) && reg_wr_data[ST_OVF_BIT];
		acc_nxt = acc_r;
		prod_nxt = prod_r;
		mcand_nxt = mcand_r;
		aux_address_reg_nxt = aux_address_reg_r;
		aux_select_pointer_nxt = aux_select_pointer_r;
		// A clear from software loses against a new overflow
		overflow_flag_nxt = overflow_flag_r && !ovf_clr;
		// Any executed instruction releases the hold set by a multiply
		int_block_nxt = instr_valid ? 1'h0 : int_block_r;
		case (op)
			OPK_LOAD_MCAND: begin
				mcand_nxt = mem_rd_data;
			end
			OPK_LOAD_ACC, OPK_LOAD_ACC_MOVE: begin
				mcand_nxt = mem_rd_data;
				acc_nxt = arith.add_sum;
				if (arith.add_ovf) begin
					overflow_flag_nxt = 1'h1;
				end
			end
			OPK_MULT_MEM, OPK_MULT_IMM: begin
				prod_nxt = arith.mul_p;
				int_block_nxt = 1'h1;
			end
			OPK_OR_LOW: begin
				acc_nxt[DATA_W-1:0] = acc_r[DATA_W-1:0] | mem_rd_data;
			end
			default: begin
			end
		endcase
		// Direct mode leaves the aux state alone
		if (addr_op && indirect) begin
			if (step_up) begin
				aux_address_reg_nxt[aux_select_pointer_r] = cur_aux + AUX_STEP;
			end else if (step_down) begin
				aux_address_reg_nxt[aux_select_pointer_r] = cur_aux - AUX_STEP;
			end
			if (!instr_word[IND_KEEP_PTR_BIT]) begin
				aux_select_pointer_nxt = instr_word[IND_NEXT_PTR_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_r <= ACC_RESET;
			prod_r <= ACC_RESET;
			mcand_r <= DATA_RESET;
			aux_address_reg_r[0] <= DATA_RESET;
			aux_address_reg_r[1] <= DATA_RESET;
			aux_select_pointer_r <= BIT_RESET;
			overflow_flag_r <= BIT_RESET;
			int_block_r <= BIT_RESET;
		end else begin
			acc_r <= acc_nxt;
			prod_r <= prod_nxt;
			mcand_r <= mcand_nxt;
			aux_address_reg_r <= aux_address_reg_nxt;
			aux_select_pointer_r <= aux_select_pointer_nxt;
			overflow_flag_r <= overflow_flag_nxt;
			int_block_r <= int_block_nxt;
		end
	end

	assign int_block = int_block_r;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_comb begin
		overflow_saturate_mode_nxt = overflow_saturate_mode_r;
		page_select_bit_nxt = page_select_bit_r;
		if (reg_wr && (reg_addr == REG_CTRL)) begin
			overflow_saturate_mode_nxt = reg_wr_data[CTRL_SAT_BIT];
			page_select_bit_nxt = reg_wr_data[CTRL_PAGE_BIT];
		end
		// Read data stands for one cycle only, zero otherwise
		rd_data_nxt = DATA_RESET;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: begin
					rd_data_nxt[CTRL_SAT_BIT] = overflow_saturate_mode_r;
					rd_data_nxt[CTRL_PAGE_BIT] = page_select_bit_r;
				end
				REG_STATUS: begin
					rd_data_nxt[ST_OVF_BIT] = overflow_flag_r;
					rd_data_nxt[ST_PTR_BIT] = aux_select_pointer_r;
					rd_data_nxt[ST_BLOCK_BIT] = int_block_r;
				end
				REG_ACC_LO: rd_data_nxt = acc_r[DATA_W-1:0];
				REG_ACC_HI: rd_data_nxt = acc_r[ACC_W-1:DATA_W];
				REG_PROD_LO: rd_data_nxt = prod_r[DATA_W-1:0];
				REG_PROD_HI: rd_data_nxt = prod_r[ACC_W-1:DATA_W];
				REG_MCAND: rd_data_nxt = mcand_r;
				REG_AUX0: rd_data_nxt = aux_address_reg_r[0];
				REG_AUX1: rd_data_nxt = aux_address_reg_r[1];
				default: rd_data_nxt = DATA_RESET;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			overflow_saturate_mode_r <= BIT_RESET;
			page_select_bit_r <= BIT_RESET;
			rd_data_r <= DATA_RESET;
		end else begin
			overflow_saturate_mode_r <= overflow_saturate_mode_nxt;
			page_select_bit_r <= page_select_bit_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	assign reg_rd_data = rd_data_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence mult_taken;
		(op == OPK_MULT_MEM) || (op == OPK_MULT_IMM);
	endsequence

	// Release follows any valid word, recognised or not
	sequence held_until_next;
		int_block_r && !instr_valid ##1 int_block_r;
	endsequence

	load_mcand_a: assert property (
		(op == OPK_LOAD_MCAND) |=> mcand_r == $past(mem_rd_data))
		else $error("multiplicand not loaded from memory");

	direct_addr_a: assert property (
		(op == OPK_LOAD_MCAND) && !indirect |->
		mem_rd_addr == {page_select_bit_r, instr_word[DIR_OFF_W-1:0]})
		else $error("direct address wrong");

	acc_add_a: assert property (
		(op == OPK_LOAD_ACC) && !overflow_saturate_mode_r |=>
		acc_r == $past(acc_r) + $past(prod_r) && mcand_r == $past(mem_rd_data))
		else $error("accumulate result wrong");

	move_write_a: assert property (
		(op == OPK_LOAD_ACC_MOVE) |-> mem_wr_en && mem_wr_data == mem_rd_data &&
		mem_wr_addr == mem_rd_addr + ADDR_STEP)
		else $error("data move write wrong");

	modify_nomem_a: assert property (
		(op == OPK_MODIFY_AUX) |-> !mem_rd_en && !mem_wr_en ##1 $stable(acc_r))
		else $error("modify-aux touched memory");

	modify_direct_a: assert property (
		(op == OPK_MODIFY_AUX) && !indirect |=> $stable(aux_address_reg_r[0]) &&
		$stable(aux_address_reg_r[1]) && $stable(aux_select_pointer_r))
		else $error("direct modify-aux changed state");

	ptr_load_a: assert property (
		(op == OPK_MODIFY_AUX) && indirect && !instr_word[IND_INC_BIT] &&
		!instr_word[IND_DEC_BIT] && !instr_word[IND_KEEP_PTR_BIT] |=>
		aux_select_pointer_r == $past(instr_word[IND_NEXT_PTR_BIT]) &&
		$stable(aux_address_reg_r[0]) && $stable(aux_address_reg_r[1]))
		else $error("pointer load wrong");

	product_a: assert property (
		(op == OPK_MULT_MEM) && !(mcand_r == DATA_MIN_NEG && mem_rd_data == DATA_MIN_NEG) |=>
		$signed(prod_r) == $signed($past(mcand_r)) * $signed($past(mem_rd_data)))
		else $error("product wrong");

	int_hold_a: assert property (
		mult_taken |=> int_block_r)
		else $error("interrupt hold missing after multiply");

	int_keep_a: assert property (
		int_block_r && !instr_valid |-> held_until_next)
		else $error("interrupt hold dropped early");

	int_release_a: assert property (
		int_block_r && instr_valid && (op != OPK_MULT_MEM) && (op != OPK_MULT_IMM) |=>
		!int_block_r)
		else $error("interrupt hold not released");

	square_a: assert property (
		(op == OPK_MULT_MEM) && mcand_r == DATA_MIN_NEG && mem_rd_data == DATA_MIN_NEG |=>
		prod_r == PROD_MIN_SQUARE)
		else $error("most negative square wrong");

	imm_a: assert property (
		(op == OPK_MULT_IMM) |=>
		$signed(prod_r) == $signed($past(mcand_r)) * $signed($past(imm_ext)))
		else $error("immediate product wrong");

	no_op_a: assert property (
		(op == OPK_NO_OP) |-> pc_inc && !mem_rd_en ##1 $stable(acc_r) && $stable(prod_r) &&
		$stable(mcand_r) && $stable(aux_select_pointer_r))
		else $error("no-op changed state");

	or_low_a: assert property (
		(op == OPK_OR_LOW) |=> acc_r[ACC_W-1:DATA_W] == $past(acc_r[ACC_W-1:DATA_W]) &&
		acc_r[DATA_W-1:0] == ($past(acc_r[DATA_W-1:0]) | $past(mem_rd_data)))
		else $error("OR result wrong");

	ptr_select_a: assert property (
		mem_op && indirect |-> mem_rd_addr == cur_aux[MEM_AW-1:0])
		else $error("indirect address not from selected aux");

	wrap_ovf_a: assert property (
		((op == OPK_LOAD_ACC) || (op == OPK_LOAD_ACC_MOVE)) && arith.add_ovf &&
		!overflow_saturate_mode_r |=> overflow_flag_r && acc_r == $past(acc_r) + $past(prod_r))
		else $error("wrapped overflow wrong");

	sat_ovf_a: assert property (
		((op == OPK_LOAD_ACC) || (op == OPK_LOAD_ACC_MOVE)) && arith.add_ovf &&
		overflow_saturate_mode_r |=> overflow_flag_r &&
		acc_r == ($past(prod_r[ACC_W-1]) ? ACC_MAX_NEG : ACC_MAX_POS))
		else $error("saturated overflow wrong");
endmodule
`default_nettype wire

// File: testbench/dmlo_mem_model.sv
/*
 Data memory partner of the execute core: 256 words, read at once, write on the edge.
 Assumes the core moves its strobes just after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dmlo_mem_model
	import dmlo_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Core side
	input wire logic rd_en,
	input wire logic [MEM_AW-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [MEM_AW-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data
);
	logic [DATA_W-1:0] mem [0:255];
	logic [DATA_W-1:0] last;

	initial last = 16'hA5A5;
	// Unselected bus shows the inverse so a stale word never matches
	always_comb rd_data = rd_en ? mem[rd_addr] : ~last;
	always @(posedge ref_clk) begin
		if (rd_en) last <= mem[rd_addr];
		if (wr_en) mem[wr_addr] <= wr_data;
	end
endmodule
`default_nettype wire

// File: testbench/dmlo_core_tb.sv
/*
 Self-checking bench of the execute core: instruction and register-port tasks.
 Assumes the memory partner answers reads in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module dmlo_core_tb;
	import dmlo_pkg::*;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	logic ref_clk, rst_b, instr_valid, pc_inc, int_block;
	logic mem_rd_en, mem_wr_en, reg_wr, reg_rd;
	logic [DATA_W-1:0] instr_word, mem_rd_data, mem_wr_data, reg_wr_data, reg_rd_data;
	logic [MEM_AW-1:0] mem_rd_addr, mem_wr_addr, got_a, got_w;
	logic [REG_AW-1:0] reg_addr;
	logic [2:0] got_f;
	int errors, num_checks, cycles;

	dmlo_core i_dmlo_core (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_word(instr_word), .pc_inc(pc_inc), .int_block(int_block),
		.mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
		.mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rd_data(reg_rd_data));
	dmlo_mem_model i_dmlo_mem_model (.ref_clk(ref_clk), .rd_en(mem_rd_en),
		.rd_addr(mem_rd_addr), .rd_data(mem_rd_data), .wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr), .wr_data(mem_wr_data));

	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Run is under two hundred cycles; far above that means a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			complete_run();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reset_dut();
		@(posedge ref_clk);
		rst_b <= 1'h0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'h1;
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rd_data;
	endtask
	task automatic chk_reg(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] d;
		rd(a, d);
		chk({16'h0000, d}, {16'h0000, e});
	endtask
	task automatic chk_wide(input logic [REG_AW-1:0] a, input logic [ACC_W-1:0] e);
		logic [DATA_W-1:0] lo, hi;
		rd(a, lo);
		rd(a + 4'h1, hi);
		chk({hi, lo}, e);
	endtask
	// Strobes are looked at in the cycle the word is presented
	task automatic exec(input logic [DATA_W-1:0] w);
		@(posedge ref_clk);
		instr_word <= w;
		instr_valid <= 1'h1;
		#1;
		got_f = {pc_inc, mem_rd_en, mem_wr_en};
		got_a = mem_rd_addr;
		got_w = mem_wr_addr;
		@(posedge ref_clk);
		instr_valid <= 1'h0;
		#1;
	endtask
	task automatic strb(input logic [2:0] e, input logic [MEM_AW-1:0] a);
		chk({29'h0, got_f}, {29'h0, e});
		if (e[1]) chk({24'h0, got_a}, {24'h0, a});
		if (e[0]) chk({24'h0, got_w}, {24'h0, a + ADDR_STEP});
	endtask
	task automatic mult_min();
		exec(16'h6A10);
		exec(16'h6D10);
		repeat (3) exec(16'h6C10);
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{instr_valid, reg_wr, reg_rd, rst_b} = 4'h0;
		{instr_word, reg_wr_data, reg_addr} = 36'h0;
		errors = 0;
		num_checks = 0;
		cycles = 0;
		i_dmlo_mem_model.mem[8'h01] = 16'h5A5A;
		i_dmlo_mem_model.mem[8'h05] = 16'h1234;
		i_dmlo_mem_model.mem[8'hFF] = 16'h0ABC;
		i_dmlo_mem_model.mem[8'h10] = DATA_MIN_NEG;
		i_dmlo_mem_model.mem[8'h11] = 16'h0007;
		i_dmlo_mem_model.mem[8'h20] = 16'h0062;
		i_dmlo_mem_model.mem[8'h30] = 16'h80F0;
		reset_dut();
		for (int i = 0; i < 9; i++) chk_reg(4'(i), DATA_RESET);
		chk_reg(4'hF, 16'h0000);
		exec(16'h6A05);
		strb(3'h6, 8'h05);
		chk_reg(REG_MCAND, 16'h1234);
		wr(REG_CTRL, 16'h0002);
		exec(16'h6A7F);
		strb(3'h6, 8'hFF);
		chk_reg(REG_MCAND, 16'h0ABC);
		wr(REG_CTRL, 16'h0000);
		exec(16'h6A10);
		exec(16'h6D10);
		strb(3'h6, 8'h10);
		chk({31'h0, int_block}, 32'h1);
		chk_wide(REG_PROD_LO, 32'hC0000000);
		chk_reg(REG_STATUS, 16'h0004);
		exec(OP_NO_OP);
		strb(3'h4, 8'h00);
		chk({31'h0, int_block}, 32'h0);
		chk_wide(REG_PROD_LO, 32'hC0000000);
		chk_wide(REG_ACC_LO, 32'h00000000);
		exec(16'h6A11);
		exec(16'h9FF7);
		strb(3'h4, 8'h00);
		chk({31'h0, int_block}, 32'h1);
		chk_wide(REG_PROD_LO, 32'hFFFFFFC1);
		exec(16'h6C20);
		strb(3'h6, 8'h20);
		chk_wide(REG_ACC_LO, 32'hFFFFFFC1);
		chk_reg(REG_MCAND, 16'h0062);
		chk_reg(REG_STATUS, 16'h0000);
		exec(16'h6B20);
		strb(3'h7, 8'h20);
		chk_wide(REG_ACC_LO, 32'hFFFFFF82);
		chk({16'h0, i_dmlo_mem_model.mem[8'h21]}, 32'h0062);
		exec(16'h6800);
		strb(3'h4, 8'h00);
		chk_wide(REG_ACC_LO, 32'hFFFFFF82);
		exec(16'h68A8);
		strb(3'h4, 8'h00);
		chk_reg(REG_AUX0, 16'h0001);
		exec(16'h6881);
		chk_reg(REG_STATUS, 16'h0002);
		chk_reg(REG_AUX0, 16'h0001);
		exec(16'h6898);
		chk_reg(REG_AUX1, 16'hFFFF);
		exec(16'h6A88);
		strb(3'h6, 8'hFF);
		exec(16'h6880);
		exec(16'h6A88);
		strb(3'h6, 8'h01);
		reset_dut();
		mult_min();
		chk_wide(REG_ACC_LO, 32'h40000000);
		chk_reg(REG_STATUS, 16'h0001);
		exec(16'h7A30);
		strb(3'h6, 8'h30);
		chk_wide(REG_ACC_LO, 32'h400080F0);
		wr(REG_STATUS, 16'h0001);
		chk_reg(REG_STATUS, 16'h0000);
		reset_dut();
		wr(REG_CTRL, 16'h0001);
		mult_min();
		chk_wide(REG_ACC_LO, ACC_MAX_NEG);
		chk_reg(REG_STATUS, 16'h0001);
		// An unrecognised word still ends the hold after a multiply
		exec(16'h6D10);
		exec(16'h0000);
		strb(3'h0, 8'h00);
		chk({31'h0, int_block}, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
